/* File: core/fpre_defs.svh */
// Register offsets, field positions and reset values of the rounding and exception unit.
`ifndef FPRE_DEFS_SVH
`define FPRE_DEFS_SVH
`define FPRE_ADDR_W 4
`define FPRE_OFS_SCL_CTRL 4'h0
`define FPRE_OFS_SCL_STAT 4'h4
`define FPRE_OFS_SIMD_CS 4'h8
`define FPRE_SCL_MASK_LSB 0
`define FPRE_SCL_RC_LSB 10
`define FPRE_SIMD_FLAG_LSB 0
`define FPRE_SIMD_MASK_LSB 7
`define FPRE_SIMD_RC_LSB 13
`define FPRE_MASK_RST 6'h3f
`define FPRE_RC_RST 2'h0
`define FPRE_FLAG_RST 6'h00
`define FPRE_EXP_MAX 12'h0ff
`define FPRE_QNAN_INDEF 32'hffc00000
`endif

/* File: core/fpre_pkg.sv */
// Types shared by the rounding and exception unit.
package fpre_pkg;
   typedef enum logic [1:0] {
      RM_NEAREST = 2'h0,
      RM_DOWN = 2'h1,
      RM_UP = 2'h2,
      RM_TRUNC = 2'h3
   } fpre_rmode_t;
   typedef enum logic [1:0] {
      OP_ARITH = 2'h0,
      OP_TRUNC_CVT = 2'h1,
      OP_COMPARE = 2'h2,
      OP_NAN = 2'h3
   } fpre_op_t;
   // Flag and mask bit order: invalid, denormal, divide-by-zero, overflow, underflow, inexact.
   typedef struct packed {
      logic inexact;
      logic underflow;
      logic overflow;
      logic div_zero;
      logic denormal;
      logic invalid_op;
   } fpre_exc_t;
   typedef struct packed {
      logic simd;
      fpre_op_t op;
      logic pre_invalid;
      logic pre_div_zero;
      logic pre_denormal;
      logic sign;
      logic signed [11:0] exp;
      logic [25:0] sig;
   } fpre_req_t;
endpackage : fpre_pkg

/* File: core/fpre_unit.sv */
// Single-precision result rounder with sticky exception flags for a scalar and a SIMD unit.
//
// Behaviour
// - Inexact results pick a bracketing representable value.
// - Rounding error stays below one ulp.
// - Code 00 rounds nearest, ties to even.
// - Code 01 rounds toward negative infinity.
// - Code 10 rounds toward positive infinity.
// - Code 11 truncates toward zero.
// - Nearest-even is the reset rounding mode.
// - Inexact rounding sets the inexact flag.
// - Compares, exact and NaN results ignore rounding.
// - Scalar rounding control at bits 11:10.
// - SIMD rounding control at bits 14:13.
// - Truncating conversions always round toward zero.
// - Six exception classes are detected.
// - Invalid, divide-by-zero, denormal come from operands.
// - Overflow, underflow, inexact come from rounded result.
// - Flag set first; masked gives default result.
// - Unmasked exception requests the software handler.
// - Flags stay set until software clears.
// - Scalar flags and masks at bits 5:0.
// - SIMD flags 5:0, masks 12:7, independent.
// - Masked exceptions may raise several flags.
// - Masked invalid returns the quiet NaN indefinite.
// - Masked divide-by-zero returns signed infinity.
`timescale 1ns/100ps
`default_nettype none
`include "fpre_defs.svh"

module fpre_unit (
   input wire logic CLK,
   input wire logic RST,
   input wire logic CE,
   input wire logic REQ_VALID,
   input wire fpre_pkg::fpre_req_t REQ,
   output logic RES_VALID,
   output logic [31:0] RES_DATA,
   output fpre_pkg::fpre_exc_t RES_FLAGS,
   output logic HANDLER_REQ,
   input wire logic [`FPRE_ADDR_W-1:0] ADDR,
   input wire logic [31:0] WR_DATA,
   input wire logic WR_EN,
   input wire logic RD_EN,
   output logic [31:0] RD_DATA
);
   import fpre_pkg::*;

   fpre_exc_t scl_mask;
   fpre_exc_t scl_flag;
   fpre_exc_t simd_mask;
   fpre_exc_t simd_flag;
   fpre_rmode_t scl_rc;
   fpre_rmode_t simd_rc;

   fpre_rmode_t mode;
   fpre_exc_t mask;
   fpre_exc_t det;
   logic [31:0] next_res;
   logic [24:0] sum_n;
   logic [23:0] sum_d;
   logic [25:0] sig_d;
   logic signed [11:0] exp_n;
   logic [4:0] shamt;
   logic tiny;
   logic inexact;
   logic ovf;
   logic pre_stop;
   logic active;

   // Increment decision for dropping guard and sticky bits below the kept lsb.
   function automatic logic round_inc(input logic sign, input logic lsb, input logic guard,
                                      input logic sticky, input fpre_rmode_t m);
      case (m)
         RM_NEAREST: round_inc = guard & (sticky | lsb);
         RM_DOWN: round_inc = sign & (guard | sticky);
         RM_UP: round_inc = ~sign & (guard | sticky);
         RM_TRUNC: round_inc = 1'b0;
         default: round_inc = 1'b0;
      endcase
   endfunction : round_inc

   // Right shift that folds every bit shifted out into the sticky position.
   function automatic logic [25:0] shr_sticky(input logic [25:0] v, input logic [4:0] n);
      logic [25:0] r;
      logic s;
      r = v;
      s = 1'b0;
      for (int i = 0; i < 26; i++) begin
         if (i < int'(n)) begin
            s = s | r[0];
            r = {1'b0, r[25:1]};
         end
      end
      shr_sticky = {r[25:1], r[0] | s};
   endfunction : shr_sticky

   function automatic logic wr_hit(input logic [`FPRE_ADDR_W-1:0] a);
      wr_hit = WR_EN && (ADDR == a);
   endfunction : wr_hit

   always_comb begin
      mode = REQ.simd ? simd_rc : scl_rc;
      if (REQ.op == OP_TRUNC_CVT) begin
         mode = RM_TRUNC;
      end
      mask = REQ.simd ? simd_mask : scl_mask;
   end

   // Normal path: round the kept 24-bit significand, exponent left unbounded.
   always_comb begin
      sum_n = {1'b0, REQ.sig[25:2]} + {24'h0, round_inc(REQ.sign, REQ.sig[2], REQ.sig[1], REQ.sig[0], mode)};
      exp_n = REQ.exp + {11'h0, sum_n[24]};
      tiny = (exp_n < 12'sd1);
      shamt = 5'd0;
      if (REQ.exp < 12'sd1) begin
         shamt = (REQ.exp < -12'sd24) ? 5'd26 : 5'(12'sd1 - REQ.exp);
      end
      sig_d = shr_sticky(REQ.sig, shamt);
      sum_d = sig_d[25:2] + {23'h0, round_inc(REQ.sign, sig_d[2], sig_d[1], sig_d[0], mode)};
      inexact = tiny ? (|sig_d[1:0]) : (|REQ.sig[1:0]);
      ovf = !tiny && (exp_n >= $signed(`FPRE_EXP_MAX));
   end

   // Exception detection and the delivered value.
   always_comb begin
      det = '0;
      det.invalid_op = REQ.pre_invalid;
      det.div_zero = REQ.pre_div_zero && !REQ.pre_invalid;
      det.denormal = REQ.pre_denormal && !REQ.pre_invalid;
      // Arithmetic stops at an unmasked operand fault or a masked invalid or zero divide.
      pre_stop = |(det & ~mask) || det.invalid_op || det.div_zero;
      active = (REQ.op == OP_ARITH || REQ.op == OP_TRUNC_CVT) && !pre_stop;
      if (active) begin
         det.overflow = ovf;
         det.underflow = mask.underflow ? (tiny && inexact) : tiny;
         det.inexact = inexact || ovf;
      end
      next_res = '0;
      if (det.invalid_op || REQ.op == OP_NAN) begin
         next_res = `FPRE_QNAN_INDEF;
      end else if (det.div_zero) begin
         next_res = {REQ.sign, 8'hff, 23'h0};
      end else if (REQ.op == OP_COMPARE) begin
         next_res = '0;
      end else if (ovf) begin
         case (mode)
            RM_NEAREST: next_res = {REQ.sign, 8'hff, 23'h0};
            RM_DOWN: next_res = REQ.sign ? {1'b1, 8'hff, 23'h0} : {1'b0, 8'hfe, 23'h7fffff};
            RM_UP: next_res = REQ.sign ? {1'b1, 8'hfe, 23'h7fffff} : {1'b0, 8'hff, 23'h0};
            default: next_res = {REQ.sign, 8'hfe, 23'h7fffff};
         endcase
      end else if (tiny) begin
         next_res = {REQ.sign, 7'h0, sum_d[23], sum_d[22:0]};
      end else begin
         next_res = {REQ.sign, exp_n[7:0], sum_n[24] ? sum_n[23:1] : sum_n[22:0]};
      end
   end

   // Result outputs: an unmasked fault drops RES_VALID and raises the handler request; RES_DATA still loads.
   always_ff @(posedge CLK) begin
      if (RST) begin
         RES_VALID <= 1'b0;
         RES_DATA <= '0;
         RES_FLAGS <= '0;
         HANDLER_REQ <= 1'b0;
      end else if (CE) begin
         RES_VALID <= REQ_VALID && !(|(det & ~mask));
         HANDLER_REQ <= REQ_VALID && (|(det & ~mask));
         RES_FLAGS <= REQ_VALID ? det : '0;
         if (REQ_VALID) begin
            RES_DATA <= next_res;
         end
      end
   end

   // Control fields; masks and rounding reset to all masked and nearest-even.
   always_ff @(posedge CLK) begin
      if (RST) begin
         scl_mask <= `FPRE_MASK_RST;
         scl_rc <= fpre_rmode_t'(`FPRE_RC_RST);
         simd_mask <= `FPRE_MASK_RST;
         simd_rc <= fpre_rmode_t'(`FPRE_RC_RST);
      end else if (CE) begin
         if (wr_hit(`FPRE_OFS_SCL_CTRL)) begin
            scl_mask <= WR_DATA[`FPRE_SCL_MASK_LSB +: 6];
            scl_rc <= fpre_rmode_t'(WR_DATA[`FPRE_SCL_RC_LSB +: 2]);
         end
         if (wr_hit(`FPRE_OFS_SIMD_CS)) begin
            simd_mask <= WR_DATA[`FPRE_SIMD_MASK_LSB +: 6];
            simd_rc <= fpre_rmode_t'(WR_DATA[`FPRE_SIMD_RC_LSB +: 2]);
         end
      end
   end

   // Sticky flags: a detection in the same cycle as a software write still lands.
   always_ff @(posedge CLK) begin
      if (RST) begin
         scl_flag <= `FPRE_FLAG_RST;
         simd_flag <= `FPRE_FLAG_RST;
      end else if (CE) begin
         scl_flag <= (wr_hit(`FPRE_OFS_SCL_STAT) ? WR_DATA[5:0] : scl_flag)
                     | ((REQ_VALID && !REQ.simd) ? det : '0);
         simd_flag <= (wr_hit(`FPRE_OFS_SIMD_CS) ? WR_DATA[`FPRE_SIMD_FLAG_LSB +: 6] : simd_flag)
                      | ((REQ_VALID && REQ.simd) ? det : '0);
      end
   end

   // Read data stands only in the cycle after the read strobe.
   always_ff @(posedge CLK) begin
      if (RST) begin
         RD_DATA <= '0;
      end else if (CE) begin
         RD_DATA <= '0;
         if (RD_EN) begin
            case (ADDR)
               `FPRE_OFS_SCL_CTRL: RD_DATA <= {20'h0, scl_rc, 4'h0, scl_mask};
               `FPRE_OFS_SCL_STAT: RD_DATA <= {26'h0, scl_flag};
               `FPRE_OFS_SIMD_CS: RD_DATA <= {17'h0, simd_rc, simd_mask, 1'b0, simd_flag};
               default: RD_DATA <= '0;
            endcase
         end
      end
   end

   default clocking cb @(posedge CLK); endclocking
   default disable iff (RST);

   logic in_range;
   assign in_range = (REQ.exp > 12'sd1) && (REQ.exp < 12'sd250);
   logic plain_req;
   assign plain_req = REQ_VALID && CE && !REQ.pre_invalid && !REQ.pre_div_zero && !REQ.pre_denormal;

   a_reset_mode: assert property ($fell(RST) |-> scl_rc == RM_NEAREST && simd_rc == RM_NEAREST)
      else $error("rounding mode not nearest after reset");
   a_tie_even: assert property (plain_req && REQ.op == OP_ARITH && mode == RM_NEAREST && in_range
                                && REQ.sig[2:0] == 3'b010 |=> RES_DATA[22:0] == $past(REQ.sig[24:2]))
      else $error("tie not rounded to even");
   a_up_pos: assert property (plain_req && REQ.op == OP_ARITH && mode == RM_UP && !REQ.sign && in_range
                              && REQ.sig[1:0] != 2'b00 && REQ.sig[24:2] != 23'h7fffff
                              |=> RES_DATA[22:0] == $past(REQ.sig[24:2]) + 23'h1)
      else $error("positive value not rounded up");
   a_trunc_cvt: assert property (plain_req && REQ.op == OP_TRUNC_CVT && in_range
                                 |=> RES_DATA[22:0] == $past(REQ.sig[24:2]))
      else $error("truncating conversion rounded away from zero");
   a_inexact_flag: assert property (plain_req && REQ.op == OP_ARITH && in_range
                                    |=> RES_FLAGS.inexact == $past(|REQ.sig[1:0]))
      else $error("inexact flag disagrees with dropped bits");
   a_unmasked_trap: assert property (REQ_VALID && CE && REQ.pre_invalid && !mask.invalid_op
                                     |=> HANDLER_REQ && !RES_VALID)
      else $error("unmasked invalid did not request handler");
   // An unmasked denormal fault on the same operands traps instead, so it is kept out of the antecedent.
   a_masked_dz: assert property (REQ_VALID && CE && REQ.pre_div_zero && !REQ.pre_invalid && mask.div_zero
                                 && (mask.denormal || !REQ.pre_denormal)
                                 |=> RES_VALID && RES_DATA == {$past(REQ.sign), 8'hff, 23'h0})
      else $error("masked divide-by-zero result wrong");
   a_flag_sticky: assert property (CE && scl_flag.inexact && !wr_hit(`FPRE_OFS_SCL_STAT) |=> scl_flag.inexact)
      else $error("sticky flag lost");
   a_set_wins: assert property (CE && REQ_VALID && REQ.simd && det.invalid_op && wr_hit(`FPRE_OFS_SIMD_CS)
                                |=> simd_flag.invalid_op)
      else $error("detection lost under software write");
   a_compare_flags: assert property (REQ_VALID && CE && REQ.op == OP_COMPARE |=> !RES_FLAGS.inexact)
      else $error("compare raised inexact");
   a_read_slot: assert property (CE && !RD_EN |=> RD_DATA == 32'h0)
      else $error("read data outside its slot");

   c_overflow: cover property (REQ_VALID && CE && REQ.op == OP_ARITH && ovf);
   c_denorm_underflow: cover property (REQ_VALID && CE && REQ.pre_denormal && det.underflow);
   c_handler: cover property (HANDLER_REQ);
   c_tiny_result: cover property (REQ_VALID && CE && tiny && inexact);
endmodule : fpre_unit
`default_nettype wire

/* File: tb/test_fp_rounding_exception_flags.sv */
// Self-checking bench for the rounding and exception unit.
`timescale 1ns/100ps
`default_nettype none
module test_fp_rounding_exception_flags;
   import fpre_pkg::*;
   logic CLK = 1'b0;
   logic RST = 1'b1;
   logic CE = 1'b1;
   logic REQ_VALID = 1'b0;
   fpre_req_t REQ = '0;
   logic RES_VALID;
   logic [31:0] RES_DATA;
   fpre_exc_t RES_FLAGS;
   logic HANDLER_REQ;
   logic [3:0] ADDR = 4'h0;
   logic [31:0] WR_DATA = 32'h0;
   logic WR_EN = 1'b0;
   logic RD_EN = 1'b0;
   logic [31:0] RD_DATA;
   int n_errors = 0;
   int samples_checked = 0;
   int cycles = 0;
   fpre_unit dut (.CLK(CLK), .RST(RST), .CE(CE), .REQ_VALID(REQ_VALID), .REQ(REQ), .RES_VALID(RES_VALID),
      .RES_DATA(RES_DATA), .RES_FLAGS(RES_FLAGS), .HANDLER_REQ(HANDLER_REQ), .ADDR(ADDR), .WR_DATA(WR_DATA),
      .WR_EN(WR_EN), .RD_EN(RD_EN), .RD_DATA(RD_DATA));
   always #2 CLK = ~CLK;
   task automatic conclude();
      $display("Mismatches %0d, comparisons %0d", n_errors, samples_checked);
      if (n_errors == 0 && samples_checked > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : conclude
   // The ceiling is some 38 times the roughly 130 cycles the scenarios need.
   always @(posedge CLK) begin
      cycles++;
      if (cycles == 5000) begin
         n_errors++;
         conclude();
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         n_errors++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   function automatic fpre_req_t mk(input logic s, input fpre_op_t o, input logic [2:0] pre, input logic sg,
      input logic [11:0] e, input logic [25:0] m);
      return '{simd: s, op: o, pre_invalid: pre[2], pre_div_zero: pre[1], pre_denormal: pre[0], sign: sg,
         exp: e, sig: m};
   endfunction : mk
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge CLK);
      WR_EN <= 1'b1;
      ADDR <= a;
      WR_DATA <= d;
      @(posedge CLK);
      WR_EN <= 1'b0;
   endtask : wr
   task automatic rd(input logic [3:0] a, input logic [31:0] x);
      @(posedge CLK);
      RD_EN <= 1'b1;
      ADDR <= a;
      @(posedge CLK);
      RD_EN <= 1'b0;
      #1;
      chk(RD_DATA, x);
   endtask : rd
   // Operand significand carries hidden bit, fraction, guard and sticky; results show one cycle after the take.
   task automatic run(input logic s, input fpre_op_t o, input logic [2:0] pre, input logic sg, input logic [11:0] e,
      input logic [25:0] m, input logic cd, input logic [31:0] xd, input logic [5:0] xf, input logic h);
      @(posedge CLK);
      REQ_VALID <= 1'b1;
      REQ <= mk(s, o, pre, sg, e, m);
      @(posedge CLK);
      REQ_VALID <= 1'b0;
      #1;
      if (cd) begin
         chk(RES_DATA, xd);
      end
      chk({26'h0, RES_FLAGS}, {26'h0, xf});
      chk({30'h0, RES_VALID, HANDLER_REQ}, {30'h0, ~h, h});
   endtask : run
   task automatic t_reset();
      rd(4'h0, 32'h3f);
      rd(4'h4, 32'h0);
      rd(4'h8, 32'h1f80);
      rd(4'hc, 32'h0);
   endtask : t_reset
   task automatic t_modes();
      for (int i = 0; i < 4; i++) begin
         wr(4'h0, 32'h3f | (32'(i) << 10));
         run(0, OP_ARITH, 3'h0, 0, 12'd127, 26'h2000002, 1, (i == 2) ? 32'h3f800001 : 32'h3f800000, 6'h20, 0);
         run(0, OP_ARITH, 3'h0, 1, 12'd127, 26'h2000002, 1, (i == 1) ? 32'hbf800001 : 32'hbf800000, 6'h20, 0);
         run(0, OP_ARITH, 3'h0, 0, 12'd255, 26'h2000000, 1, i[0] ? 32'h7f7fffff : 32'h7f800000, 6'h28, 0);
      end
      wr(4'h0, 32'h3f);
      run(0, OP_ARITH, 3'h0, 0, 12'd127, 26'h2000006, 1, 32'h3f800002, 6'h20, 0);
      run(0, OP_ARITH, 3'h0, 0, 12'd127, 26'h2000003, 1, 32'h3f800001, 6'h20, 0);
      run(0, OP_ARITH, 3'h0, 0, 12'd127, 26'h2000000, 1, 32'h3f800000, 6'h00, 0);
      rd(4'h4, 32'h28);
   endtask : t_modes
   task automatic t_units();
      wr(4'h4, 32'h0);
      wr(4'h8, 32'h5f80);
      run(1, OP_ARITH, 3'h0, 0, 12'd127, 26'h2000002, 1, 32'h3f800001, 6'h20, 0);
      run(0, OP_ARITH, 3'h0, 0, 12'd127, 26'h2000002, 1, 32'h3f800000, 6'h20, 0);
      rd(4'h8, 32'h5fa0);
      wr(4'h0, 32'h83f);
      run(0, OP_TRUNC_CVT, 3'h0, 0, 12'd127, 26'h2000002, 1, 32'h3f800000, 6'h20, 0);
      run(0, OP_COMPARE, 3'h0, 0, 12'd127, 26'h2000002, 1, 32'h0, 6'h00, 0);
      run(0, OP_NAN, 3'h0, 0, 12'd127, 26'h2000002, 1, 32'hffc00000, 6'h00, 0);
      rd(4'h4, 32'h20);
   endtask : t_units
   task automatic t_exc();
      wr(4'h4, 32'h0);
      wr(4'h0, 32'h3f);
      run(0, OP_ARITH, 3'h4, 0, 12'd127, 26'h2000000, 1, 32'hffc00000, 6'h01, 0);
      run(0, OP_ARITH, 3'h2, 1, 12'd127, 26'h2000000, 1, 32'hff800000, 6'h04, 0);
      run(0, OP_ARITH, 3'h1, 0, 12'd127, 26'h2000002, 1, 32'h3f800000, 6'h22, 0);
      rd(4'h4, 32'h27);
      wr(4'h0, 32'h0);
      run(0, OP_ARITH, 3'h2, 0, 12'd127, 26'h2000000, 0, 32'h0, 6'h04, 1);
      run(0, OP_ARITH, 3'h0, 0, 12'd127, 26'h2000002, 0, 32'h0, 6'h20, 1);
   endtask : t_exc
   task automatic t_sticky();
      wr(4'h0, 32'h3f);
      wr(4'h4, 32'h0);
      run(0, OP_ARITH, 3'h0, 0, 12'd127, 26'h2000002, 1, 32'h3f800000, 6'h20, 0);
      run(0, OP_ARITH, 3'h0, 0, 12'd127, 26'h2000000, 1, 32'h3f800000, 6'h00, 0);
      rd(4'h4, 32'h20);
      // A clearing write that meets a fresh detection must not lose it.
      @(posedge CLK);
      REQ_VALID <= 1'b1;
      REQ <= mk(0, OP_ARITH, 3'h0, 0, 12'd127, 26'h2000002);
      WR_EN <= 1'b1;
      ADDR <= 4'h4;
      WR_DATA <= 32'h0;
      @(posedge CLK);
      REQ_VALID <= 1'b0;
      WR_EN <= 1'b0;
      rd(4'h4, 32'h20);
      wr(4'h4, 32'h0);
      rd(4'h4, 32'h0);
   endtask : t_sticky
   // A write presented while the clock enable is low must leave the control word untouched.
   task automatic t_freeze();
      @(posedge CLK);
      CE <= 1'b0;
      WR_EN <= 1'b1;
      ADDR <= 4'h0;
      WR_DATA <= 32'h0;
      @(posedge CLK);
      WR_EN <= 1'b0;
      CE <= 1'b1;
      rd(4'h0, 32'h3f);
   endtask : t_freeze
   initial begin
      repeat (20) @(posedge CLK);
      RST <= 1'b0;
      t_reset();
      t_modes();
      t_units();
      t_exc();
      t_sticky();
      t_freeze();
      conclude();
   end
endmodule : test_fp_rounding_exception_flags
`default_nettype wire
